/* logic/branch_bit_defs.svh */
// Constants for the branch and bit-set execute group.
// Assumes a 16-bit instruction word and byte-addressed program memory.
`ifndef BRANCH_BIT_DEFS_SVH
`define BRANCH_BIT_DEFS_SVH

`define OPC_BZC_HI     8'he1
`define OPC_RJMP_HI    5'h1a
`define OPC_FBS_HI     4'h8
`define OPC_TBSC_HI    4'hb
`define OPC_TBSS_HI    4'ha
`define BIT_IDX_LSB    9
`define ACCESS_BIT     8
`define INDEXED_MAX    8'h5f
`define ACCESS_SPLIT   8'h60
`define ACCESS_HI_BANK 4'hf
`define STEP_PC        21'h000002
`define Q1_RESET       4'h1

`endif

/* logic/branch_bit_pkg.sv */
// Types shared by the branch and bit-set execute group.
// Assumes the defs header is compiled alongside.
package branch_bit_pkg;

  typedef struct packed {
    logic        zero;
    logic        ext_en;
    logic [3:0]  bank;
    logic [7:0]  fsr2_low;
  } core_state_type;

  typedef struct packed {
    logic        we;
    logic [11:0] addr;
    logic [7:0]  wdata;
  } file_wr_type;

endpackage

/* logic/file_addr_calc.sv */
// File register address calculation for bit-oriented instructions.
// Assumes the core supplies bank and index base as levels.
`timescale 1ns/100ps
module file_addr_calc
  import branch_bit_pkg::*;
(
  input  wire logic [7:0]     i_faddr,
  input  wire logic           i_access_sel,
  input  wire core_state_type i_core,
  output logic [11:0]         o_addr
);
  `include "branch_bit_defs.svh"

  always_comb begin
    if (i_access_sel) begin
      o_addr = {i_core.bank, i_faddr};
    end else if (i_core.ext_en && i_faddr <= `INDEXED_MAX) begin
      // Indexed literal offset: base + literal, kept in one page
      o_addr = {4'h0, 8'(i_core.fsr2_low + i_faddr)};
    end else if (i_faddr < `ACCESS_SPLIT) begin
      o_addr = {4'h0, i_faddr};
    end else begin
      o_addr = {`ACCESS_HI_BANK, i_faddr};
    end
  end
endmodule

/* logic/branch_bit_exec.sv */
// Execute unit for the zero-clear branch, relative jump, bit set and
// bit test skip instructions. Runs a four-phase Q1..Q4 cycle.
// Assumes i_pc is already the incremented PC and file reads are combinational.
`timescale 1ns/100ps

// Overview of operation
// - Branch-if-zero-clear opcode E1 branches only while zero flag is 0.
// - Conditional offset is signed 8-bit, doubled to a byte displacement.
// - Target is incremented PC plus twice the signed offset.
// - Conditional branch takes two cycles taken, one cycle not taken.
// - Taken: Q4 writes PC then a full no-op cycle; untaken Q4 idle.
// - Relative jump 1101_0 with signed 11-bit offset always branches.
// - Relative jump doubles offset and ends with a no-op cycle.
// - File bit set sets selected bit, other bits unchanged.
// - Access flag 0 picks access bank, 1 uses bank select register.
// - Access 0, extended mode, address up to 95 uses indexed offset.
// - Skip-if-clear discards prefetched word when tested bit is 0.
// - Skip-if-set discards prefetched word when tested bit is 1.
module branch_bit_exec
  import branch_bit_pkg::*;
#(
  parameter int PC_W = 21
)(
  input  wire logic                            i_sys_clk,
  input  wire logic                            i_rst,
  input  wire logic                            i_instr_valid,
  input  wire logic [15:0]                     i_instr,
  input  wire logic [PC_W-1:0]                 i_pc,
  input  wire branch_bit_pkg::core_state_type  i_core,
  input  wire logic [7:0]                      i_file_rdata,
  output logic [11:0]                          o_file_addr,
  output branch_bit_pkg::file_wr_type          o_file_wr,
  output logic                                 o_pc_we,
  output logic [PC_W-1:0]                      o_pc_new,
  output logic                                 o_flush,
  output logic                                 o_status_we,
  output logic [3:0]                           o_phase
);
  import branch_bit_pkg::*;
  `include "branch_bit_defs.svh"

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  typedef enum logic [3:0] {
    PH_Q1 = 4'b0001,
    PH_Q2 = 4'b0010,
    PH_Q3 = 4'b0100,
    PH_Q4 = 4'b1000
  } phase_type;

  typedef struct packed {
    phase_type       phase;
    logic [15:0]     ir;
    logic            nop_cycle;
    logic [7:0]      data;
    logic            take;
    logic [PC_W-1:0] target;
    logic            pc_we;
    logic [PC_W-1:0] pc_new;
    logic            flush;
    file_wr_type     wr;
  } state_type;

  state_type st_reg;
  state_type st_next;

  logic [11:0]     faddr;
  logic            is_bzc;
  logic            is_rjmp;
  logic            is_fbs;
  logic            is_tbsc;
  logic            is_tbss;
  logic [2:0]      bit_idx;
  logic [PC_W-1:0] disp;

  file_addr_calc u_addr (
    .i_faddr      (st_reg.ir[7:0]),
    .i_access_sel (st_reg.ir[`ACCESS_BIT]),
    .i_core       (i_core),
    .o_addr       (faddr)
  );

  // ------------------------------------------------------------------
  // Decode
  // ------------------------------------------------------------------
  assign is_bzc  = ~st_reg.nop_cycle && st_reg.ir[15:8] == `OPC_BZC_HI;
  assign is_rjmp = ~st_reg.nop_cycle && st_reg.ir[15:11] == `OPC_RJMP_HI;
  assign is_fbs  = ~st_reg.nop_cycle && st_reg.ir[15:12] == `OPC_FBS_HI;
  assign is_tbsc = ~st_reg.nop_cycle && st_reg.ir[15:12] == `OPC_TBSC_HI;
  assign is_tbss = ~st_reg.nop_cycle && st_reg.ir[15:12] == `OPC_TBSS_HI;
  assign bit_idx = st_reg.ir[`BIT_IDX_LSB +: 3];

  // Sign extend then double; the relative jump has 11 offset bits
  always_comb begin
    if (is_rjmp) begin
      disp = PC_W'({{(PC_W-11){st_reg.ir[10]}}, st_reg.ir[10:0]} << 1);
    end else begin
      disp = PC_W'({{(PC_W-8){st_reg.ir[7]}}, st_reg.ir[7:0]} << 1);
    end
  end

  // ------------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------------
  always_comb begin
    st_next       = st_reg;
    st_next.pc_we = 1'b0;
    st_next.flush = 1'b0;
    st_next.wr.we = 1'b0;
    case (st_reg.phase)
      PH_Q1: begin
        st_next.phase = PH_Q2;
        st_next.take  = 1'b0;
      end
      PH_Q2: begin
        st_next.phase = PH_Q3;
        st_next.data  = i_file_rdata;
      end
      PH_Q3: begin
        st_next.phase  = PH_Q4;
        st_next.target = i_pc + disp;
        st_next.take   = is_rjmp ||
                         (is_bzc && !i_core.zero);
        if (is_fbs) begin
          st_next.data[bit_idx] = 1'b1;
        end
        if ((is_tbsc && !st_reg.data[bit_idx]) ||
            (is_tbss && st_reg.data[bit_idx])) begin
          st_next.take = 1'b1;
        end
      end
      PH_Q4: begin
        st_next.phase = PH_Q1;
        // Skipped word and taken branches both cost one no-op cycle
        st_next.nop_cycle = st_reg.take;
        st_next.flush     = st_reg.take;
        if (st_reg.take && (is_bzc || is_rjmp)) begin
          st_next.pc_we  = 1'b1;
          st_next.pc_new = st_reg.target;
        end
        if (is_fbs) begin
          st_next.wr.we    = 1'b1;
          st_next.wr.addr  = faddr;
          st_next.wr.wdata = st_reg.data;
        end
        st_next.ir = i_instr_valid ? i_instr : 16'h0000;
      end
      default: begin
        st_next.phase = PH_Q1;
      end
    endcase
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      st_reg       <= '0;
      st_reg.phase <= PH_Q1;
    end else begin
      st_reg <= st_next;
    end
  end

  // Write-side outputs are registered one edge late so they land in Q1
  assign o_file_addr = (st_reg.phase == PH_Q1) ? st_reg.wr.addr : faddr;
  assign o_file_wr   = st_reg.wr;
  assign o_pc_we     = st_reg.pc_we;
  assign o_pc_new    = st_reg.pc_new;
  assign o_flush     = st_reg.flush;
  assign o_status_we = 1'b0;
  assign o_phase     = st_reg.phase;

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  sequence s_q4_taken;
    st_reg.phase == PH_Q4 && st_reg.take;
  endsequence

  property p_status_quiet;
    @(posedge i_sys_clk) disable iff (i_rst) !o_status_we;
  endproperty
  a_status_quiet: assert property (p_status_quiet)
    else $error("status write from branch group");

  property p_bzc_zero_blocks;
    @(posedge i_sys_clk) disable iff (i_rst)
      (st_reg.phase == PH_Q3 && is_bzc && i_core.zero) ##1 1'b1
      |=> !o_pc_we;
  endproperty
  a_bzc_zero_blocks: assert property (p_bzc_zero_blocks)
    else $error("branch taken with zero set");

  property p_bzc_target;
    @(posedge i_sys_clk) disable iff (i_rst)
      (st_reg.phase == PH_Q3 && is_bzc && !i_core.zero)
      |-> ##2 (o_pc_we &&
               o_pc_new == $past(i_pc, 2) +
                           {{(PC_W-9){$past(st_reg.ir[7], 2)}},
                            $past(st_reg.ir[7:0], 2), 1'b0});
  endproperty
  a_bzc_target: assert property (p_bzc_target)
    else $error("wrong conditional branch target");

  property p_taken_nop;
    @(posedge i_sys_clk) disable iff (i_rst)
      s_q4_taken |=> st_reg.nop_cycle [*4];
  endproperty
  a_taken_nop: assert property (p_taken_nop)
    else $error("taken branch lacks no-op cycle");

  property p_pc_write_q1;
    @(posedge i_sys_clk) disable iff (i_rst)
      o_pc_we |-> st_reg.phase == PH_Q1 && $past(st_reg.take);
  endproperty
  a_pc_write_q1: assert property (p_pc_write_q1)
    else $error("PC written outside Q4 edge");

  property p_rjmp_always;
    @(posedge i_sys_clk) disable iff (i_rst)
      (st_reg.phase == PH_Q3 && is_rjmp) |=> st_reg.take ##1 o_pc_we;
  endproperty
  a_rjmp_always: assert property (p_rjmp_always)
    else $error("relative jump not taken");

  property p_fbs_write;
    @(posedge i_sys_clk) disable iff (i_rst)
      (st_reg.phase == PH_Q3 && is_fbs) |-> ##2
        (o_file_wr.we &&
         o_file_wr.wdata == ($past(st_reg.data, 2) |
                             (8'h01 << $past(bit_idx, 2))));
  endproperty
  a_fbs_write: assert property (p_fbs_write)
    else $error("bit set result wrong");

  property p_skip_flush;
    @(posedge i_sys_clk) disable iff (i_rst)
      (st_reg.phase == PH_Q3 &&
       ((is_tbsc && !st_reg.data[bit_idx]) ||
        (is_tbss && st_reg.data[bit_idx]))) |-> ##2 (o_flush && !o_pc_we);
  endproperty
  a_skip_flush: assert property (p_skip_flush)
    else $error("skip did not discard prefetched word");

  property p_bank_addr;
    @(posedge i_sys_clk) disable iff (i_rst)
      (st_reg.phase != PH_Q1 && st_reg.ir[`ACCESS_BIT])
      |-> o_file_addr == {i_core.bank, st_reg.ir[7:0]};
  endproperty
  a_bank_addr: assert property (p_bank_addr)
    else $error("bank select not applied");

  property p_indexed_addr;
    @(posedge i_sys_clk) disable iff (i_rst)
      (st_reg.phase != PH_Q1 && !st_reg.ir[`ACCESS_BIT] && i_core.ext_en &&
       st_reg.ir[7:0] <= `INDEXED_MAX)
      |-> o_file_addr[11:8] == 4'h0 &&
          o_file_addr[7:0] == 8'(i_core.fsr2_low + st_reg.ir[7:0]);
  endproperty
  a_indexed_addr: assert property (p_indexed_addr)
    else $error("indexed literal offset not applied");

endmodule

/* sim/tb.sv */
// Self-checking bench for the branch and bit-set execute unit.
// Assumes the design package and defs header are compiled first.
`timescale 1ns/100ps
module tb;
  import branch_bit_pkg::*;

  localparam int PC_W = 21;
  localparam logic [3:0] PH_Q1 = 4'h1;
  localparam logic [3:0] PH_Q3 = 4'h4;

  logic            i_sys_clk;
  logic            i_rst;
  logic            i_instr_valid;
  logic [15:0]     i_instr;
  logic [PC_W-1:0] i_pc;
  core_state_type  i_core;
  logic [7:0]      i_file_rdata;
  logic [11:0]     o_file_addr;
  file_wr_type     o_file_wr;
  logic            o_pc_we;
  logic [PC_W-1:0] o_pc_new;
  logic            o_flush;
  logic            o_status_we;
  logic [3:0]      o_phase;
  int              failures;
  int              checks;

  branch_bit_exec #(.PC_W(PC_W)) u_dut (
    .i_sys_clk    (i_sys_clk),
    .i_rst        (i_rst),
    .i_instr_valid(i_instr_valid),
    .i_instr      (i_instr),
    .i_pc         (i_pc),
    .i_core       (i_core),
    .i_file_rdata (i_file_rdata),
    .o_file_addr  (o_file_addr),
    .o_file_wr    (o_file_wr),
    .o_pc_we      (o_pc_we),
    .o_pc_new     (o_pc_new),
    .o_flush      (o_flush),
    .o_status_we  (o_status_we),
    .o_phase      (o_phase)
  );

  initial begin
    i_sys_clk = 1'b0;
    forever #2.5 i_sys_clk = ~i_sys_clk;
  end

  // ----------------------------------------------------------------
  // Reference model and checking
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic close_out;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  function automatic logic [11:0] f_addr(input logic [15:0] w,
                                         input core_state_type c);
    if (w[8]) return {c.bank, w[7:0]};
    if (c.ext_en && w[7:0] <= 8'h5f) return {4'h0, c.fsr2_low + w[7:0]};
    return (w[7:0] < 8'h60) ? {4'h0, w[7:0]} : {4'hf, w[7:0]};
  endfunction

  // Bounded wait for the Q3 phase, seen at the falling edge
  task automatic wait_q3;
    int n;
    n = 0;
    do begin
      @(negedge i_sys_clk);
      n++;
      if (n > 8) begin
        check("q3 wait timeout", 32'h1, 32'h0);
        close_out();
      end
    end while (o_phase !== PH_Q3);
  endtask

  // One instruction, then a bit-set word that is discarded after a
  // taken branch or skip and executed otherwise.
  task automatic step(input logic [15:0] w, input logic zero);
    core_state_type  c;
    logic [PC_W-1:0] pc, tgt;
    logic [7:0]      rd, frd;
    logic [15:0]     fw;
    logic            tk, sk, bs, bv;
    c = 14'($urandom);
    c.zero = zero;
    pc = PC_W'($urandom) & ~PC_W'(1);
    rd = 8'($urandom);
    frd = 8'($urandom);
    fw = {4'h8, 12'($urandom)};
    tk = 1'b0;
    sk = 1'b0;
    tgt = '0;
    bs = (w[15:12] == 4'h8);
    bv = rd[w[11:9]];
    if (w[15:8] == 8'he1) begin
      tk = !zero;
      tgt = pc + PC_W'(2 * int'($signed(w[7:0])));
    end
    if (w[15:11] == 5'h1a) begin
      tk = 1'b1;
      tgt = pc + PC_W'(2 * int'($signed(w[10:0])));
    end
    if (w[15:12] == 4'hb) sk = !bv;
    if (w[15:12] == 4'ha) sk = bv;
    wait_q3();
    @(posedge i_sys_clk);
    i_instr_valid <= 1'b1;
    i_instr <= w;
    i_core <= c;
    i_pc <= pc;
    i_file_rdata <= rd;
    repeat (2) @(posedge i_sys_clk);
    i_instr <= fw;
    #1;
    if (w[15:14] == 2'b10) begin
      check("read addr", o_file_addr, f_addr(w, c));
    end
    repeat (2) @(posedge i_sys_clk);
    i_file_rdata <= frd;
    @(posedge i_sys_clk);
    i_instr_valid <= 1'b0;
    i_instr <= 16'($urandom);
    #1;
    check("phase q1", o_phase, PH_Q1);
    check("pc_we", o_pc_we, tk);
    check("flush", o_flush, tk | sk);
    check("status_we", o_status_we, 1'b0);
    check("wr_we", o_file_wr.we, bs);
    if (tk) check("pc_new", o_pc_new, tgt);
    if (bs) check("wr_addr", o_file_wr.addr, f_addr(w, c));
    if (bs) begin
      check("wr_data", o_file_wr.wdata, rd | (8'h01 << w[11:9]));
    end
    repeat (4) @(posedge i_sys_clk);
    #1;
    check("next we", o_file_wr.we,
          !(tk | sk));
    check("next pc_we", o_pc_we, 1'b0);
    if (!(tk | sk)) begin
      check("next addr", o_file_wr.addr, f_addr(fw, c));
      check("next data", o_file_wr.wdata,
            frd | (8'h01 << fw[11:9]));
    end
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [15:0] dw[8];
    logic [15:0] w;
    failures = 0;
    checks = 0;
    i_rst = 1'b1;
    i_instr_valid = 1'b0;
    i_instr = 16'h0000;
    i_pc = '0;
    i_core = '0;
    i_file_rdata = 8'h00;
    void'($urandom(32'h51050a63));
    repeat (3) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    // Offset extremes and address boundaries come first
    dw = '{16'he180, 16'he17f, 16'hd400, 16'hd3ff,
           16'h8e5f, 16'h8060, 16'h8fff, 16'hb15f};
    foreach (dw[i]) begin
      step(dw[i], 1'b0);
      step(dw[i], 1'b1);
    end
    $display("directed test done");
    for (int i = 0; i < 80; i++) begin
      w = 16'($urandom);
      case ($urandom_range(0, 4))
        0: w[15:8] = 8'he1;
        1: w[15:11] = 5'h1a;
        2: w[15:12] = 4'h8;
        3: w[15:12] = 4'hb;
        default: w[15:12] = 4'ha;
      endcase
      step(w, 1'($urandom));
    end
    $display("random test done");
    close_out();
  end
endmodule
